// ---- hdl/vfps_top.sv ----
// V/F output pattern generator with contact-selected preset speeds.
// Assumes contact pins are asynchronous; all other inputs are on clock.
`include "vfps_cfg.svh"

module vfps_top
  import vfps_pkg::*;
(
  input wire logic clock, // 200 MHz
  input wire logic resetn, // Async reset
  input wire logic [6:0] terminal_in, // Contact pins
  input wire logic fwd_run, // Forward rotation
  input wire logic rev_run, // Reverse rotation
  input wire logic vector_mode, // Either vector control mode
  input wire logic single_phase_100v, // Supply doubled model
  input wire logic [15:0] supply_volt, // Measured supply, 1 V
  input wire logic [15:0] output_freq, // Ramped output frequency
  input wire logic [1:0] write_protect_setting, // 0 default
  input wire logic wr_en, // Settings write strobe
  input wire vfps_sel_t wr_sel, // Which setting
  input wire logic [3:0] wr_idx, // Preset or terminal index
  input wire logic [15:0] wr_data, // Setting value
  output logic wr_ack, // Write taken
  output logic wr_err, // Write refused
  output vfps_cmd_t cmd // Frequency and voltage command
);

  // Settings storage
  logic [15:0] base_voltage_setting_q;
  logic [15:0] base_frequency_setting_q;
  logic [15:0] second_base_frequency_setting_q;
  logic [1:0] load_pattern_setting_q;
  logic [15:0] torque_boost_setting_q;
  logic [15:0] second_torque_boost_setting_q;
  logic [15:0] rated_motor_voltage_setting_q;
  logic [15:0] rated_motor_frequency_setting_q;
  logic [1:0] accel_pattern_setting_q;
  logic [7:0] input_terminal_assign_settings_q [7];
  logic [15:0] preset_q [16];
  logic [6:0] term_meta_q;
  logic [6:0] term_sync_q;
  vfps_contacts_t contacts;
  logic running;
  logic wr_ok;

  // Frequency setting in range or the unset code
  function automatic logic freq_ok(input logic [15:0] v, input logic allow_unset);
    freq_ok = (v <= `VFPS_FREQ_MAX) || (allow_unset && v == `VFPS_CODE_UNSET);
  endfunction

  // Percentage of a voltage
  function automatic logic [15:0] pct_of(input logic [15:0] v, input logic [15:0] pct);
    logic [31:0] p;
    p = (32'(v) * 32'(pct)) / 32'(`VFPS_PCT100);
    pct_of = p[15:0];
  endfunction

  // Pin inputs pass two flops; only the second one is decoded
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      term_meta_q <= 7'h00;
      term_sync_q <= 7'h00;
    end else begin
      term_meta_q <= terminal_in;
      term_sync_q <= term_meta_q;
    end
  end

  // Terminal function decode
  always_comb begin
    contacts = '0;
    for (int i = 0; i < 7; i++) begin
      if (term_sync_q[i]) begin
        if (input_terminal_assign_settings_q[i] == `VFPS_FN_SECOND)
          contacts.second_function_select = 1'b1;
        if (input_terminal_assign_settings_q[i] == `VFPS_FN_LOW)
          contacts.speed_select_low = 1'b1;
        if (input_terminal_assign_settings_q[i] == `VFPS_FN_MID)
          contacts.speed_select_mid = 1'b1;
        if (input_terminal_assign_settings_q[i] == `VFPS_FN_HIGH)
          contacts.speed_select_high = 1'b1;
        if (input_terminal_assign_settings_q[i] == `VFPS_FN_EXT)
          contacts.speed_select_extension = 1'b1;
      end
    end
  end

  // Write acceptance; presets bypass protection so speeds can change on the fly
  assign running = fwd_run | rev_run;
  always_comb begin
    wr_ok = 1'b0;
    unique case (wr_sel)
      VFPS_SEL_PRESET:
        wr_ok = freq_ok(wr_data, wr_idx > 4'h3) && wr_idx != 4'h0;
      VFPS_SEL_BASE_VOLT:
        wr_ok = wr_data <= `VFPS_VOLT_MAX || wr_data == `VFPS_CODE_V95 || wr_data == `VFPS_CODE_UNSET;
      VFPS_SEL_BASE_FREQ, VFPS_SEL_RATED_FREQ:
        wr_ok = freq_ok(wr_data, 1'b0);
      VFPS_SEL_SECOND_FREQ:
        wr_ok = freq_ok(wr_data, 1'b1);
      VFPS_SEL_PATTERN, VFPS_SEL_ACCEL:
        wr_ok = wr_data <= 16'h0003;
      VFPS_SEL_BOOST:
        wr_ok = wr_data <= `VFPS_BOOST_MAX;
      VFPS_SEL_BOOST2:
        wr_ok = wr_data <= `VFPS_BOOST_MAX || wr_data == `VFPS_CODE_UNSET;
      VFPS_SEL_RATED_VOLT:
        wr_ok = wr_data <= `VFPS_VOLT_MAX;
      VFPS_SEL_TERMINAL:
        wr_ok = wr_idx < 4'h7;
      default:
        wr_ok = 1'b0;
    endcase
    // Other settings are locked while running, or always when protected
    if (wr_sel != VFPS_SEL_PRESET && (write_protect_setting != 2'h0 || running))
      wr_ok = 1'b0;
  end

  // Write answer, one cycle after the strobe
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_ack <= 1'b0;
      wr_err <= 1'b0;
    end else begin
      wr_ack <= wr_en & wr_ok;
      wr_err <= wr_en & ~wr_ok;
    end
  end

  // Scalar settings
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      base_voltage_setting_q <= `VFPS_RST_BASE_VOLT;
      base_frequency_setting_q <= `VFPS_RST_BASE_FREQ;
      second_base_frequency_setting_q <= `VFPS_RST_SECOND_FREQ;
      load_pattern_setting_q <= `VFPS_RST_PATTERN;
      torque_boost_setting_q <= `VFPS_RST_BOOST;
      second_torque_boost_setting_q <= `VFPS_RST_BOOST2;
      rated_motor_voltage_setting_q <= `VFPS_RST_RATED_VOLT;
      rated_motor_frequency_setting_q <= `VFPS_RST_RATED_FREQ;
      accel_pattern_setting_q <= `VFPS_RST_ACCEL;
    end else if (wr_en && wr_ok) begin
      unique case (wr_sel)
        VFPS_SEL_BASE_VOLT: base_voltage_setting_q <= wr_data;
        VFPS_SEL_BASE_FREQ: base_frequency_setting_q <= wr_data;
        VFPS_SEL_SECOND_FREQ: second_base_frequency_setting_q <= wr_data;
        VFPS_SEL_PATTERN: load_pattern_setting_q <= wr_data[1:0];
        VFPS_SEL_BOOST: torque_boost_setting_q <= wr_data;
        VFPS_SEL_BOOST2: second_torque_boost_setting_q <= wr_data;
        VFPS_SEL_RATED_VOLT: rated_motor_voltage_setting_q <= wr_data;
        VFPS_SEL_RATED_FREQ: rated_motor_frequency_setting_q <= wr_data;
        VFPS_SEL_ACCEL: accel_pattern_setting_q <= wr_data[1:0];
        default: ;
      endcase
    end
  end

  // Terminal assignment and preset tables
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 7; i++)
        input_terminal_assign_settings_q[i] <= `VFPS_FN_NONE;
      input_terminal_assign_settings_q[0] <= `VFPS_FN_LOW;
      input_terminal_assign_settings_q[1] <= `VFPS_FN_MID;
      input_terminal_assign_settings_q[2] <= `VFPS_FN_HIGH;
      input_terminal_assign_settings_q[3] <= `VFPS_FN_SECOND;
      for (int i = 0; i < 16; i++)
        preset_q[i] <= `VFPS_CODE_UNSET;
      preset_q[1] <= `VFPS_RST_PRESET_HIGH;
      preset_q[2] <= `VFPS_RST_PRESET_MID;
      preset_q[3] <= `VFPS_RST_PRESET_LOW;
    end else if (wr_en && wr_ok) begin
      if (wr_sel == VFPS_SEL_TERMINAL)
        input_terminal_assign_settings_q[wr_idx[2:0]] <= wr_data[7:0];
      if (wr_sel == VFPS_SEL_PRESET)
        preset_q[wr_idx] <= wr_data;
    end
  end

  // Preset speed choice
  logic [3:0] combo_speed;
  logic [3:0] fallback_speed;
  logic [3:0] speed_d;
  logic any_sel;
  always_comb begin
    any_sel = contacts.speed_select_high | contacts.speed_select_mid |
              contacts.speed_select_low | contacts.speed_select_extension;
    // Priority among the three basic inputs, lower ranked wins
    if (contacts.speed_select_low)
      fallback_speed = 4'h3;
    else if (contacts.speed_select_mid)
      fallback_speed = 4'h2;
    else if (contacts.speed_select_high)
      fallback_speed = 4'h1;
    else
      fallback_speed = 4'h3;
    // Combination table for speeds 4 to 15
    unique case ({contacts.speed_select_extension, contacts.speed_select_high,
                  contacts.speed_select_mid, contacts.speed_select_low})
      4'b0011: combo_speed = 4'h4;
      4'b0101: combo_speed = 4'h5;
      4'b0110: combo_speed = 4'h6;
      4'b0111: combo_speed = 4'h7;
      4'b1000: combo_speed = 4'h8;
      4'b1001: combo_speed = 4'h9;
      4'b1010: combo_speed = 4'ha;
      4'b1011: combo_speed = 4'hb;
      4'b1100: combo_speed = 4'hc;
      4'b1101: combo_speed = 4'hd;
      4'b1110: combo_speed = 4'he;
      4'b1111: combo_speed = 4'hf;
      default: combo_speed = 4'h0;
    endcase
    // An unset extended preset falls back to the basic priority
    if (combo_speed != 4'h0 && preset_q[combo_speed] != `VFPS_CODE_UNSET)
      speed_d = combo_speed;
    else
      speed_d = fallback_speed;
  end

  // Effective base point; second settings follow the select input
  logic [15:0] fbase;
  logic [15:0] vbase_dec;
  logic [15:0] vsupply;
  logic [15:0] vmax;
  logic [15:0] boost;
  logic second_f_valid;
  always_comb begin
    vsupply = single_phase_100v ? 16'(supply_volt << 1) : supply_volt;
    second_f_valid = contacts.second_function_select &&
                     second_base_frequency_setting_q != `VFPS_CODE_UNSET;
    if (vector_mode)
      fbase = rated_motor_frequency_setting_q;
    else if (second_f_valid)
      fbase = second_base_frequency_setting_q;
    else
      fbase = base_frequency_setting_q;
    if (base_voltage_setting_q == `VFPS_CODE_V95)
      vbase_dec = pct_of(vsupply, `VFPS_PCT95);
    else if (base_voltage_setting_q == `VFPS_CODE_UNSET)
      vbase_dec = vsupply;
    else
      vbase_dec = base_voltage_setting_q;
    if (vector_mode)
      vbase_dec = rated_motor_voltage_setting_q;
    // Output can never exceed what the supply delivers
    vmax = (vbase_dec < vsupply) ? vbase_dec : vsupply;
    if (contacts.second_function_select && second_torque_boost_setting_q != `VFPS_CODE_UNSET)
      boost = second_torque_boost_setting_q;
    else
      boost = torque_boost_setting_q;
  end

  // Voltage pattern; the divide is costly but keeps the ratio exact
  logic [16:0] ratio;
  logic [31:0] ratio_raw;
  logic [33:0] ratio_sq;
  logic [47:0] lin_v;
  logic [47:0] sq_v;
  logic [47:0] boost_v;
  logic [47:0] boost_full;
  logic use_boost;
  logic [47:0] volt_sum;
  logic [15:0] volt_d;
  always_comb begin
    ratio_raw = (fbase == 16'h0000) ? 32'h0 : ({output_freq, 16'h0000} / 32'(fbase));
    if (fbase == 16'h0000 || output_freq >= fbase)
      ratio = `VFPS_ONE_Q16;
    else
      ratio = ratio_raw[16:0];
    ratio_sq = (34'(ratio) * 34'(ratio)) >> 16;
    lin_v = (48'(vmax) * 48'(ratio)) >> 16;
    sq_v = (48'(vmax) * 48'(ratio_sq)) >> 16;
    boost_full = (48'(vmax) * 48'(boost)) / 48'(`VFPS_BOOST_FULL);
    boost_v = (boost_full * 48'(`VFPS_ONE_Q16 - ratio)) >> 16;
    unique case (load_pattern_setting_q)
      2'h0: use_boost = 1'b1;
      2'h1: use_boost = 1'b0;
      2'h2: use_boost = ~rev_run;
      2'h3: use_boost = ~fwd_run;
    endcase
    if (vector_mode) begin
      volt_sum = lin_v;
    end else if (load_pattern_setting_q == 2'h1) begin
      volt_sum = sq_v;
    end else begin
      volt_sum = lin_v + (use_boost ? boost_v : 48'h0);
    end
    volt_d = (volt_sum > 48'(vmax)) ? vmax : volt_sum[15:0];
  end

  // Registered command to the power stage
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmd <= '0;
    end else begin
      cmd.volt <= volt_d;
      cmd.preset_active <= any_sel;
      cmd.preset_speed <= any_sel ? speed_d : 4'h0;
      cmd.freq <= any_sel ? preset_q[speed_d] : 16'h0000;
      // S-ramp knee stays on the base or second base setting even in vector mode
      if (accel_pattern_setting_q == `VFPS_ACCEL_S_A)
        cmd.s_knee_freq <= second_f_valid ? second_base_frequency_setting_q : base_frequency_setting_q;
      else
        cmd.s_knee_freq <= 16'h0000;
    end
  end

endmodule // vfps_top

// ---- hdl/vfps_cfg.svh ----
// Constants for the V/F pattern and preset speed selector.
// Assumes frequencies in 0.1 Hz, voltages in 1 V, boosts in 0.1 %.
`ifndef VFPS_CFG_SVH
`define VFPS_CFG_SVH
// Special setting codes
`define VFPS_CODE_UNSET 16'h270f
`define VFPS_CODE_V95 16'h22b8
// Ranges
`define VFPS_FREQ_MAX 16'h0fa0
`define VFPS_VOLT_MAX 16'h03e8
`define VFPS_BOOST_MAX 16'h012c
`define VFPS_PCT95 16'h005f
`define VFPS_PCT100 16'h0064
`define VFPS_BOOST_FULL 16'h03e8
// Codes of the terminal function assignment
`define VFPS_FN_LOW 8'h00
`define VFPS_FN_MID 8'h01
`define VFPS_FN_HIGH 8'h02
`define VFPS_FN_SECOND 8'h03
`define VFPS_FN_EXT 8'h08
`define VFPS_FN_NONE 8'hff
// Reset values
`define VFPS_RST_BASE_VOLT 16'h270f
`define VFPS_RST_BASE_FREQ 16'h0258
`define VFPS_RST_SECOND_FREQ 16'h270f
`define VFPS_RST_PATTERN 2'h0
`define VFPS_RST_BOOST 16'h003c
`define VFPS_RST_BOOST2 16'h270f
`define VFPS_RST_RATED_VOLT 16'h00c8
`define VFPS_RST_RATED_FREQ 16'h0258
`define VFPS_RST_ACCEL 2'h0
`define VFPS_RST_PRESET_HIGH 16'h0258
`define VFPS_RST_PRESET_MID 16'h012c
`define VFPS_RST_PRESET_LOW 16'h0064
// Accel pattern code for S-pattern A
`define VFPS_ACCEL_S_A 2'h1
// Ratio one in Q16
`define VFPS_ONE_Q16 17'h10000
`endif

// ---- hdl/vfps_pkg.sv ----
// Types shared by the V/F pattern and preset speed selector.
// Assumes the constants header is included by the user.
package vfps_pkg;
  // Target of a settings write
  typedef enum logic [3:0] {
    VFPS_SEL_BASE_VOLT = 4'h0,
    VFPS_SEL_BASE_FREQ = 4'h1,
    VFPS_SEL_SECOND_FREQ = 4'h2,
    VFPS_SEL_PATTERN = 4'h3,
    VFPS_SEL_BOOST = 4'h4,
    VFPS_SEL_BOOST2 = 4'h5,
    VFPS_SEL_RATED_VOLT = 4'h6,
    VFPS_SEL_RATED_FREQ = 4'h7,
    VFPS_SEL_ACCEL = 4'h8,
    VFPS_SEL_TERMINAL = 4'h9,
    VFPS_SEL_PRESET = 4'ha
  } vfps_sel_t;

  // Decoded contact functions
  typedef struct packed {
    logic second_function_select;
    logic speed_select_extension;
    logic speed_select_high;
    logic speed_select_mid;
    logic speed_select_low;
  } vfps_contacts_t;

  // Command to the power stage
  typedef struct packed {
    logic [15:0] freq;
    logic [15:0] volt;
    logic [15:0] s_knee_freq;
    logic preset_active;
    logic [3:0] preset_speed;
  } vfps_cmd_t;
endpackage

// ---- testbench/vfps_top_monitor.sv ----
// Port checker for the V/F pattern and preset speed selector.
// Assumes one clock domain and the async active-low reset of the top.
module vfps_top_monitor
  import vfps_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic resetn, // Reset
  input wire logic [6:0] terminal_in, // Contacts
  input wire logic vector_mode, // Vector mode
  input wire logic single_phase_100v, // Doubled supply
  input wire logic [15:0] supply_volt, // Supply
  input wire logic wr_en, // Write strobe
  input wire vfps_sel_t wr_sel, // Target
  input wire logic [3:0] wr_idx, // Index
  input wire logic [15:0] wr_data, // Value
  input wire logic wr_ack, // Taken
  input wire logic wr_err, // Refused
  input wire vfps_cmd_t cmd // Command
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  // Write answers
  property p_one_answer;
    wr_en |=> (wr_ack ^ wr_err);
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("write not answered once");
  property p_no_stray;
    (wr_ack || wr_err) |-> $past(wr_en);
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("answer without write");
  property p_preset_open;
    wr_en && wr_sel == VFPS_SEL_PRESET && wr_idx >= 4'h4 && wr_data <= 16'h0fa0 |=> wr_ack;
  endproperty
  a_preset_open: assert property (p_preset_open) else $error("preset write refused");
  property p_preset_zero;
    wr_en && wr_sel == VFPS_SEL_PRESET && wr_idx == 4'h0 |=> wr_err;
  endproperty
  a_preset_zero: assert property (p_preset_zero) else $error("preset zero taken");

  // Voltage never above the supply limit outside vector mode
  property p_volt_cap;
    !$past(vector_mode) |-> {1'b0, cmd.volt} <=
      ($past(single_phase_100v) ? {$past(supply_volt), 1'b0} : {1'b0, $past(supply_volt)});
  endproperty
  a_volt_cap: assert property (p_volt_cap) else $error("volt above supply");

  // Preset selection
  property p_active_speed;
    cmd.preset_active |-> cmd.preset_speed != 4'h0 && cmd.freq <= 16'h0fa0;
  endproperty
  a_active_speed: assert property (p_active_speed) else $error("bad preset speed");
  property p_idle_freq;
    !cmd.preset_active |-> cmd.freq == 16'h0000 && cmd.preset_speed == 4'h0;
  endproperty
  a_idle_freq: assert property (p_idle_freq) else $error("freq without preset");
  // Sync takes two edges and the command one more, so four quiet samples are just enough
  property p_contacts_off;
    (terminal_in == 7'h00) [*4] |-> !cmd.preset_active;
  endproperty
  a_contacts_off: assert property (p_contacts_off) else $error("preset with no contact");

  c_speed4: cover property (cmd.preset_speed == 4'h4);
  c_refused: cover property (wr_err);
  c_vector: cover property (vector_mode && cmd.volt != 16'h0000);
endmodule // vfps_top_monitor

bind vfps_top vfps_top_monitor u_vfps_top_monitor (.clock, .resetn, .terminal_in, .vector_mode,
  .single_phase_100v, .supply_volt, .wr_en, .wr_sel, .wr_idx, .wr_data, .wr_ack, .wr_err, .cmd);

// ---- testbench/vfps_contact_model.sv ----
// Contact switches wired to the selector's terminal pins.
// Assumes terminal 4 carries extension, terminal 5 second select.
module vfps_contact_model
  import vfps_pkg::*;
(
  input wire vfps_contacts_t want, // Contacts to close
  input wire logic clock, // Bench clock
  output logic [6:0] terminal_in // Pin levels
);
  timeunit 1ns;
  timeprecision 1ps;
  initial terminal_in = 7'h00;
  // Switches move just after an edge; terminal 3 left open on purpose
  always @(posedge clock) begin
    terminal_in <= {1'b0, want.second_function_select, want.speed_select_extension, 1'b0,
      want.speed_select_high, want.speed_select_mid, want.speed_select_low};
  end
endmodule // vfps_contact_model

// ---- testbench/tb.sv ----
// Self-checking bench for the V/F pattern and preset speed selector.
// Assumes the checker is bound by its own file.
module tb
  import vfps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, resetn, fwd_run, rev_run, vector_mode, single_phase_100v, wr_en, wr_ack, wr_err;
  logic [15:0] supply_volt, output_freq, wr_data;
  logic [1:0] write_protect_setting;
  logic [3:0] wr_idx;
  logic [6:0] terminal_in;
  vfps_sel_t wr_sel;
  vfps_cmd_t cmd;
  vfps_contacts_t want;
  int error_cnt, n_tests;

  vfps_top u_vfps_top (.clock, .resetn, .terminal_in, .fwd_run, .rev_run, .vector_mode,
    .single_phase_100v, .supply_volt, .output_freq, .write_protect_setting, .wr_en, .wr_sel,
    .wr_idx, .wr_data, .wr_ack, .wr_err, .cmd);
  vfps_contact_model u_vfps_contact_model (.want, .clock, .terminal_in);

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One write; the answer is looked at in its single cycle
  task automatic wr(input vfps_sel_t s, input logic [3:0] i, input logic [15:0] d, input logic ok);
    wr_en <= 1'b1;
    wr_sel <= s;
    wr_idx <= i;
    wr_data <= d;
    @(posedge clock);
    wr_en <= 1'b0;
    #1;
    chk16({14'h0, wr_ack, wr_err}, {14'h0, ok, !ok});
    @(posedge clock);
  endtask

  // Contacts need model edge, two sync edges and the command edge
  task automatic cont(input logic [4:0] w, input logic [3:0] sp, input logic [15:0] f);
    want <= w;
    repeat (5) @(posedge clock);
    #1;
    chk16(cmd.freq, f);
    chk16({12'h0, cmd.preset_speed}, {12'h0, sp});
    chk16({15'h0, cmd.preset_active}, {15'h0, sp != 4'h0});
    @(posedge clock);
  endtask

  task automatic vchk(input logic [15:0] v, input logic [15:0] k);
    repeat (5) @(posedge clock);
    #1;
    chk16(cmd.volt, v);
    chk16(cmd.s_knee_freq, k);
    @(posedge clock);
  endtask

  task automatic give_verdict();
    $display("compared %0d, wrong %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Whole run is under 2 us; a hang is cut well past that
  initial begin
    #20000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    int i;
    {resetn, fwd_run, rev_run, vector_mode, single_phase_100v, wr_en} = 6'h00;
    supply_volt = 16'h00c8;
    output_freq = 16'h0258;
    write_protect_setting = 2'h0;
    wr_sel = VFPS_SEL_BASE_VOLT;
    wr_idx = 4'h0;
    wr_data = 16'h0000;
    want = 5'h00;
    error_cnt = 0;
    n_tests = 0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    cont(5'h01, 4'h3, 16'h0064);
    cont(5'h02, 4'h2, 16'h012c);
    cont(5'h04, 4'h1, 16'h0258);
    cont(5'h06, 4'h2, 16'h012c);
    cont(5'h07, 4'h3, 16'h0064);
    wr(VFPS_SEL_TERMINAL, 4'h4, 16'h0008, 1'b1);
    cont(5'h08, 4'h3, 16'h0064);
    cont(5'h00, 4'h0, 16'h0000);
    $display("test presets done");
    // Running and protected: only presets may change
    fwd_run <= 1'b1;
    write_protect_setting <= 2'h1;
    wr(VFPS_SEL_PRESET, 4'h0, 16'h0010, 1'b0);
    wr(VFPS_SEL_PRESET, 4'h4, 16'h0fa1, 1'b0);
    wr(VFPS_SEL_PRESET, 4'h1, 16'h270f, 1'b0);
    wr(VFPS_SEL_PRESET, 4'h3, 16'h270f, 1'b0);
    wr(VFPS_SEL_PATTERN, 4'h0, 16'h0001, 1'b0);
    wr(VFPS_SEL_PRESET, 4'h3, 16'h0fa0, 1'b1);
    for (i = 4; i < 16; i++) wr(VFPS_SEL_PRESET, i[3:0], {8'h01, i[3:0], 4'h0}, 1'b1);
    for (i = 4; i < 16; i++) cont((i == 4) ? 5'h03 : i[4:0], i[3:0], {8'h01, i[3:0], 4'h0});
    cont(5'h01, 4'h3, 16'h0fa0);
    cont(5'h00, 4'h0, 16'h0000);
    fwd_run <= 1'b0;
    write_protect_setting <= 2'h0;
    $display("test running writes done");
    vchk(16'h00c8, 16'h0000);
    wr(VFPS_SEL_BASE_VOLT, 4'h0, 16'h22b8, 1'b1);
    vchk(16'h00be, 16'h0000);
    wr(VFPS_SEL_BASE_VOLT, 4'h0, 16'h0096, 1'b1);
    vchk(16'h0096, 16'h0000);
    wr(VFPS_SEL_BASE_VOLT, 4'h0, 16'h270f, 1'b1);
    single_phase_100v <= 1'b1;
    supply_volt <= 16'h0064;
    vchk(16'h00c8, 16'h0000);
    single_phase_100v <= 1'b0;
    supply_volt <= 16'h00c8;
    output_freq <= 16'h012c;
    vchk(16'h006a, 16'h0000);
    wr(VFPS_SEL_PATTERN, 4'h0, 16'h0004, 1'b0);
    wr(VFPS_SEL_PATTERN, 4'h0, 16'h0001, 1'b1);
    vchk(16'h0032, 16'h0000);
    wr(VFPS_SEL_PATTERN, 4'h0, 16'h0002, 1'b1);
    rev_run <= 1'b1;
    vchk(16'h0064, 16'h0000);
    {rev_run, fwd_run} <= 2'b01;
    vchk(16'h006a, 16'h0000);
    fwd_run <= 1'b0;
    wr(VFPS_SEL_PATTERN, 4'h0, 16'h0003, 1'b1);
    fwd_run <= 1'b1;
    vchk(16'h0064, 16'h0000);
    {rev_run, fwd_run} <= 2'b10;
    vchk(16'h006a, 16'h0000);
    rev_run <= 1'b0;
    wr(VFPS_SEL_PATTERN, 4'h0, 16'h0001, 1'b1);
    vector_mode <= 1'b1;
    vchk(16'h0064, 16'h0000);
    vector_mode <= 1'b0;
    $display("test patterns done");
    wr(VFPS_SEL_PATTERN, 4'h0, 16'h0000, 1'b1);
    wr(VFPS_SEL_BOOST2, 4'h0, 16'h0078, 1'b1);
    wr(VFPS_SEL_TERMINAL, 4'h3, 16'h00ff, 1'b1);
    wr(VFPS_SEL_TERMINAL, 4'h5, 16'h0003, 1'b1);
    want <= 5'h10;
    vchk(16'h0070, 16'h0000);
    wr(VFPS_SEL_SECOND_FREQ, 4'h0, 16'h012c, 1'b1);
    vchk(16'h00c8, 16'h0000);
    wr(VFPS_SEL_ACCEL, 4'h0, 16'h0001, 1'b1);
    vector_mode <= 1'b1;
    vchk(16'h0064, 16'h012c);
    want <= 5'h00;
    vchk(16'h0064, 16'h0258);
    $display("test second set done");
    give_verdict();
  end
endmodule // tb
